// file: rtl/sslp_defs.svh
`ifndef SSLP_DEFS_SVH
`define SSLP_DEFS_SVH
// transfer lengths in shift clocks
`define SSLP_LEN_NONE 6'h00
`define SSLP_LEN_CFG 6'h08
`define SSLP_LEN_REF 6'h10
`define SSLP_LEN_TUN 6'h18
`define SSLP_LEN_MAX 6'h3f
// field positions
`define SSLP_SEL_HI 23
`define SSLP_SEL_LO 22
`define SSLP_N_MSB 17
`define SSLP_N_LSB 6
`define SSLP_A_MSB 5
`define SSLP_DIV_MSB 12
`define SSLP_TOP_MSB 15
`define SSLP_TOP_LSB 13
`define SSLP_PORT_BIT 1
`define SSLP_DRAIN_BIT 0
`define SSLP_MSB 23
// reset values
`define SSLP_CFG_RST 8'h00
`define SSLP_TUN_RST 24'h40_0000
`define SSLP_DIV_RST 13'h0000
`define SSLP_TOP_RST 3'h0
`define SSLP_RCNT_RST 13'h0000
`define SSLP_FCNT_RST 18'h0_0000
`define SSLP_ONE13 13'h0001
`define SSLP_ONE18 18'h0_0001
`endif

// file: rtl/sslp_pkg.sv
package sslp_pkg;
   // output selector modes, in the order of their two-bit code
   typedef enum logic [1:0] {
      SSLP_MODE_PORT,
      SSLP_MODE_DOUT,
      SSLP_MODE_FB,
      SSLP_MODE_REF
   } sslp_mode_t;
endpackage

// file: rtl/sslp_port.sv
// Function
// R1: bits arrive msb first, captured on each rising shift clock.
// R2: transfer length 8, 16 or 24 picks config, reference or tuning.
// R3: registers stay put while shifting, load on strobe rising edge.
// R4: low 13 reference bits double buffered, 16-bit load hits buffer one.
// R5: top 3 reference bits take effect right after a 16-bit load.
// R6: a 24-bit load also copies buffer one into buffer two.
// R7: strobe pulse with no clocks copies buffer one into buffer two only.
// R8: host keeps main count not below swallow count.
// R9: no address bits; all bits are data; any register order.
// R10: in data-out mode shift register leaves on falling shift clock.
// R11: strobe high ignores clocks and keeps port initialized.
// R12: host frames each write strobe high, low, shift, high.
// R13: strobe edge with clock high desyncs; strobe high clock low resyncs.
// R14: tuning bits 23 and 22 select the multipurpose output source.
// R15: reference pulse low with high pulses, ratio 5..8191, one bypasses.
// R16: feedback pulse from 12-bit main counter, ratio n times 64 plus a.
// R17: host keeps both divided rates under the comparison limit.
// R18: after power-up the multipurpose output is cascade data-out.
// R19: port mode drives the config port level bit.
// R20: open-drain output low when drain bit 0, released when 1.
// R21: reset forces the open-drain output low.
// R22: host holds clock low or strobe high at power-up.
// R23: lengths other than 0, 8, 16, 24 change no register.
`include "sslp_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sslp_port (
   // system
   input wire logic mclk,
   input wire logic nrst,
   // serial port pins
   input wire logic sclk,
   input wire logic sdata,
   input wire logic transfer_strobe_n,
   // divider inputs
   input wire logic ref_in,
   input wire logic rf_in,
   // outputs
   output logic out_a,
   output logic out_b_o,
   output logic out_b_oe,
   output logic [2:0] ref_mode
);
   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic sclk_m_q, sclk_s_q, sclk_d_q;
   logic din_m_q, din_s_q;
   logic st_m_q, st_s_q, st_d_q;
   logic ref_m_q, ref_s_q, ref_d_q;
   logic rf_m_q, rf_s_q, rf_d_q;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         sclk_m_q <= 1'b0;
         sclk_s_q <= 1'b0;
         sclk_d_q <= 1'b0;
         din_m_q <= 1'b0;
         din_s_q <= 1'b0;
         st_m_q <= 1'b1;
         st_s_q <= 1'b1;
         st_d_q <= 1'b1;
         ref_m_q <= 1'b0;
         ref_s_q <= 1'b0;
         ref_d_q <= 1'b0;
         rf_m_q <= 1'b0;
         rf_s_q <= 1'b0;
         rf_d_q <= 1'b0;
      end else begin
         sclk_m_q <= sclk;
         sclk_s_q <= sclk_m_q;
         sclk_d_q <= sclk_s_q;
         din_m_q <= sdata;
         din_s_q <= din_m_q;
         st_m_q <= transfer_strobe_n;
         st_s_q <= st_m_q;
         st_d_q <= st_s_q;
         ref_m_q <= ref_in;
         ref_s_q <= ref_m_q;
         ref_d_q <= ref_s_q;
         rf_m_q <= rf_in;
         rf_s_q <= rf_m_q;
         rf_d_q <= rf_s_q;
      end
   end
   // ---------------------------------------------------------------
   // edge decode
   // ---------------------------------------------------------------
   wire sclk_rise = sclk_s_q & ~sclk_d_q;
   wire sclk_fall = ~sclk_s_q & sclk_d_q;
   wire st_rise = st_s_q & ~st_d_q;
   wire st_edge = st_s_q ^ st_d_q;
   wire ref_edge = ref_s_q & ~ref_d_q;
   wire rf_edge = rf_s_q & ~rf_d_q;
   // ---------------------------------------------------------------
   // shift path
   // ---------------------------------------------------------------
   logic [23:0] shift_q;
   logic [5:0] cnt_q;
   logic dout_q;
   logic desync_q;
   // R13: edge with clock high
   wire desync_set = st_edge & sclk_s_q;
   wire resync = st_s_q & ~sclk_s_q;
   wire desync_d = desync_set | (desync_q & ~resync);
   // R11: shifting only while selected
   wire active = ~st_s_q & ~desync_q;
   wire sh_en = active & sclk_rise;
   wire out_en = active & sclk_fall;
   // a stray strobe edge must not load a half-framed word
   wire load_evt = st_rise & ~desync_q & ~desync_set;
   wire cnt_full = (cnt_q == `SSLP_LEN_MAX);
   wire [5:0] cnt_inc = cnt_full ? cnt_q : cnt_q + 6'h01;
   wire [5:0] cnt_d = st_s_q ? `SSLP_LEN_NONE : (sh_en ? cnt_inc : cnt_q);
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         shift_q <= 24'h00_0000;
         cnt_q <= `SSLP_LEN_NONE;
         dout_q <= 1'b0;
         desync_q <= 1'b0;
      end else begin
         // R1: msb first capture
         if (sh_en)
            shift_q <= {shift_q[22:0], din_s_q};
         // R10: half stage out
         if (out_en)
            dout_q <= shift_q[`SSLP_MSB];
         cnt_q <= cnt_d;
         desync_q <= desync_d;
      end
   end
   // ---------------------------------------------------------------
   // register loads
   // ---------------------------------------------------------------
   // R2: length steers load
   // R9: no address bits
   wire ld_cfg = load_evt & (cnt_q == `SSLP_LEN_CFG);
   wire ld_ref = load_evt & (cnt_q == `SSLP_LEN_REF);
   wire ld_tun = load_evt & (cnt_q == `SSLP_LEN_TUN);
   wire ld_nul = load_evt & (cnt_q == `SSLP_LEN_NONE);
   // R6: copy on tuning
   // R7: copy on empty pulse
   wire ld_buf2 = ld_tun | ld_nul;
   logic [7:0] cfg_q;
   logic [12:0] buf1_q, buf2_q;
   logic [2:0] top_q;
   logic [23:0] tun_q;
   // R3: loads only at strobe rise
   // R23: odd lengths fall through
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         // R21: drain bit cleared
         cfg_q <= `SSLP_CFG_RST;
         buf1_q <= `SSLP_DIV_RST;
         buf2_q <= `SSLP_DIV_RST;
         top_q <= `SSLP_TOP_RST;
         // R18: data-out at power-up
         tun_q <= `SSLP_TUN_RST;
      end else begin
         if (ld_cfg)
            cfg_q <= shift_q[7:0];
         // R4: first buffer only
         // R5: top bits direct
         if (ld_ref) begin
            buf1_q <= shift_q[`SSLP_DIV_MSB:0];
            top_q <= shift_q[`SSLP_TOP_MSB:`SSLP_TOP_LSB];
         end
         if (ld_tun)
            tun_q <= shift_q;
         if (ld_buf2)
            buf2_q <= buf1_q;
      end
   end
   // ---------------------------------------------------------------
   // dividers
   // ---------------------------------------------------------------
   // R15: ratio from buffer two, one bypasses
   wire [12:0] ref_last = buf2_q - `SSLP_ONE13;
   // R16: n times 64 plus a
   wire [11:0] n_val = tun_q[`SSLP_N_MSB:`SSLP_N_LSB];
   wire [5:0] a_val = tun_q[`SSLP_A_MSB:0];
   wire [17:0] fb_ratio = {n_val, 6'h00} + {12'h000, a_val};
   wire [17:0] fb_last = fb_ratio - `SSLP_ONE18;
   logic [12:0] rcnt_q;
   logic [17:0] fcnt_q;
   logic ref_pls_q, fb_pls_q;
   wire ref_wrap = ref_edge & (rcnt_q >= ref_last);
   wire fb_wrap = rf_edge & (fcnt_q >= fb_last);
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rcnt_q <= `SSLP_RCNT_RST;
         fcnt_q <= `SSLP_FCNT_RST;
         ref_pls_q <= 1'b0;
         fb_pls_q <= 1'b0;
      end else begin
         if (ref_edge)
            rcnt_q <= ref_wrap ? `SSLP_RCNT_RST : rcnt_q + `SSLP_ONE13;
         if (rf_edge)
            fcnt_q <= fb_wrap ? `SSLP_FCNT_RST : fcnt_q + `SSLP_ONE18;
         ref_pls_q <= ref_wrap;
         fb_pls_q <= fb_wrap;
      end
   end
   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   sslp_pkg::sslp_mode_t mode;
   assign mode = sslp_pkg::sslp_mode_t'(
      {tun_q[`SSLP_SEL_HI], tun_q[`SSLP_SEL_LO]});
   logic out_a_d;
   // R14: output selector
   // R19: port level
   always_comb begin
      unique case (mode)
         sslp_pkg::SSLP_MODE_PORT: out_a_d = cfg_q[`SSLP_PORT_BIT];
         sslp_pkg::SSLP_MODE_DOUT: out_a_d = dout_q;
         sslp_pkg::SSLP_MODE_FB: out_a_d = fb_pls_q;
         sslp_pkg::SSLP_MODE_REF: out_a_d = ref_pls_q;
      endcase
   end
   logic out_a_q, out_b_oe_q;
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         out_a_q <= 1'b0;
         out_b_oe_q <= 1'b1;
      end else begin
         out_a_q <= out_a_d;
         // R20: drive low while bit clear
         out_b_oe_q <= ~cfg_q[`SSLP_DRAIN_BIT];
      end
   end
   assign out_a = out_a_q;
   assign out_b_o = 1'b0;
   assign out_b_oe = out_b_oe_q;
   assign ref_mode = top_q;
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   property p_shift;
      sh_en |=> shift_q[0] == $past(din_s_q);
   endproperty
   a_shift: assert property (p_shift) else $error("bit not captured"); // R1
   property p_cfg;
      ld_cfg |=> cfg_q == $past(shift_q[7:0]) && $stable(tun_q);
   endproperty
   a_cfg: assert property (p_cfg) else $error("config load bad"); // R2
   property p_hold;
      !load_evt |=> $stable(cfg_q) && $stable(tun_q) && $stable(buf1_q);
   endproperty
   a_hold: assert property (p_hold) else $error("load off strobe"); // R3
   property p_buf1;
      ld_ref |=> buf1_q == $past(shift_q[12:0]) && $stable(buf2_q);
   endproperty
   a_buf1: assert property (p_buf1) else $error("buffer one bad"); // R4
   property p_top;
      ld_ref |=> ref_mode == $past(shift_q[15:13]);
   endproperty
   a_top: assert property (p_top) else $error("top bits late"); // R5
   property p_tun;
      ld_tun |=> buf2_q == $past(buf1_q) && tun_q == $past(shift_q);
   endproperty
   a_tun: assert property (p_tun) else $error("tuning load bad"); // R6
   property p_nul;
      ld_nul |=> buf2_q == $past(buf1_q) && $stable(cfg_q);
   endproperty
   a_nul: assert property (p_nul) else $error("empty pulse bad"); // R7
   property p_dout;
      out_en |=> dout_q == $past(shift_q[23]);
   endproperty
   a_dout: assert property (p_dout) else $error("data out bad"); // R10
   property p_idle;
      st_s_q |=> cnt_q == `SSLP_LEN_NONE && $stable(shift_q);
   endproperty
   a_idle: assert property (p_idle) else $error("shift when idle"); // R11
   property p_sync;
      desync_set |-> !load_evt ##1 desync_q;
   endproperty
   a_sync: assert property (p_sync) else $error("no desync"); // R13
   property p_port;
      mode == sslp_pkg::SSLP_MODE_PORT |=> out_a == $past(cfg_q[1]);
   endproperty
   a_port: assert property (p_port) else $error("port level bad"); // R19
   property p_dsel;
      mode == sslp_pkg::SSLP_MODE_DOUT |=> out_a == $past(dout_q);
   endproperty
   a_dsel: assert property (p_dsel) else $error("select bad"); // R14
   property p_od;
      ld_cfg |=> ##1 out_b_oe == !$past(shift_q[0], 2);
   endproperty
   a_od: assert property (p_od) else $error("drain bad"); // R20
   property p_bad;
      load_evt && !(ld_cfg || ld_ref || ld_tun || ld_nul) |=>
         $stable(cfg_q) && $stable(buf1_q) && $stable(buf2_q) &&
         $stable(tun_q);
   endproperty
   a_bad: assert property (p_bad) else $error("odd length loaded"); // R23
   property p_fr;
      ref_wrap |=> ref_pls_q ##1 !ref_pls_q;
   endproperty
   a_fr: assert property (p_fr) else $error("ref pulse bad"); // R15
   c_cfg: cover property (ld_cfg);
   c_tun: cover property (ld_ref ##[1:1000] ld_tun);
   c_sync: cover property (desync_set ##[1:200] !desync_q);
endmodule
`default_nettype wire

// file: verif/sslp_host.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// host side of the shift port
// ----------------------------------------
module sslp_host (
   // shift port pins
   output logic sclk,
   output logic sdata,
   output logic transfer_strobe_n,
   // cascade data coming back
   input wire logic dout
);
   logic [31:0] seen;

   // strobe high and clock low from power-up
   initial begin
      sclk = 1'b0;
      sdata = 1'b1;
      transfer_strobe_n = 1'b1;
      seen = 32'h0000_0000;
   end

   // mode 0 plain, 1 strobe edge with clock high, 2 idle clocks first
   task automatic send(input logic [31:0] w, input int n, input int mode);
      int i;
      seen = 32'h0000_0000;
      if (mode == 2) begin
         repeat (8) begin
            #400 sclk = 1'b1;
            #400 sclk = 1'b0;
         end
      end
      // deliberate misuse: strobe moves while clock high
      if (mode == 1) sclk = 1'b1;
      // strobe starts high, goes low, bits, back high
      #400 transfer_strobe_n = 1'b0;
      #400 sclk = 1'b0;
      for (i = n - 1; i >= 0; i--) begin
         // msb first, data settled before the rising clock
         sdata = w[i];
         #400 sclk = 1'b1;
         #200 seen = {seen[30:0], dout};
         #200 sclk = 1'b0;
      end
      #400 transfer_strobe_n = 1'b1;
      // inverted line: the last data bit's level is not left behind
      sdata = ~sdata;
      #800;
   endtask
endmodule
`default_nettype wire

// file: verif/sslp_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sslp_port_bench;
   logic mclk, nrst, ref_in, rf_in, ref_run, rf_run;
   logic sclk, sdata, strobe_n, out_a, out_b_o, out_b_oe;
   logic [2:0] ref_mode;
   logic [31:0] w;
   logic [7:0] cfg;
   int failures, num_checks, cycles, ref_edges, rf_edges, i;

   sslp_host host_u (.sclk(sclk), .sdata(sdata),
      .transfer_strobe_n(strobe_n), .dout(out_a));
   sslp_port dut_u (.mclk(mclk), .nrst(nrst), .sclk(sclk), .sdata(sdata),
      .transfer_strobe_n(strobe_n), .ref_in(ref_in), .rf_in(rf_in),
      .out_a(out_a), .out_b_o(out_b_o), .out_b_oe(out_b_oe),
      .ref_mode(ref_mode));

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // ----------------------------------------
   // divider inputs and watchdog
   // ----------------------------------------
   // inputs toggle every 3 cycles, far under the compare limit
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles % 3 == 0 && ref_run) ref_in <= #10 ~ref_in;
      if (cycles % 3 == 0 && rf_run) rf_in <= #10 ~rf_in;
      if (cycles > 40000) begin
         failures++;
         end_of_test();
      end
   end
   always @(posedge ref_in) ref_edges++;
   always @(posedge rf_in) rf_edges++;

   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask

   // skip two pulses so a ratio change has settled
   task automatic ratio(input bit fb, input int exp);
      int a;
      repeat (2) @(posedge out_a);
      a = fb ? rf_edges : ref_edges;
      @(posedge out_a);
      check("ratio", (fb ? rf_edges : ref_edges) - a, exp);
      @(posedge mclk) #10;
   endtask

   task automatic end_of_test;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      nrst = 1'b0;
      ref_in = 1'b0;
      rf_in = 1'b0;
      ref_run = 1'b0;
      rf_run = 1'b0;
      failures = 0;
      num_checks = 0;
      void'($urandom(32'h5208));
      repeat (4) @(posedge mclk);
      #10 nrst = 1'b1;
      repeat (4) @(posedge mclk);
      #10;
      check("oe", out_b_oe, 1);
      check("od", out_b_o, 0);
      // 32 clocks: first byte reappears after 24 stages, nothing loads
      w = $urandom;
      host_u.send(w, 32, 0);
      check("dout", host_u.seen[7:0], w[31:24]);
      check("oe", out_b_oe, 1);
      check("mode", ref_mode, 0);
      // port mode, then config writes; idle clocks first time
      host_u.send(32'h0000_0000, 24, 0);
      for (i = 0; i < 4; i++) begin
         cfg = $urandom;
         host_u.send(cfg, 8, i == 0 ? 2 : 0);
         check("oe", out_b_oe, !cfg[0]);
         check("port", out_a, cfg[1]);
      end
      // strobe edge while clock high: frame refused, next one works
      host_u.send({cfg[7:1], ~cfg[0]}, 8, 1);
      check("oe", out_b_oe, !cfg[0]);
      for (i = 0; i < 3; i++) begin
         w = $urandom;
         host_u.send(w[15:0], 16, 0);
         check("mode", ref_mode, w[15:13]);
      end
      // reference ratios, never falling
      host_u.send(32'h0000_0001, 16, 0);
      host_u.send(32'h0000_0000, 0, 0);
      check("oe", out_b_oe, !cfg[0]);
      host_u.send(32'h00C0_0000, 24, 0);
      ref_run = 1'b1;
      ratio(0, 1);
      host_u.send(32'h0000_0005, 16, 0);
      host_u.send(32'h0000_0000, 0, 0);
      ratio(0, 5);
      host_u.send(32'h0000_0009, 16, 0);
      ratio(0, 5);
      host_u.send(32'h00C0_0000, 24, 0);
      ratio(0, 9);
      // feedback word keeps main count 4 above swallow count 3
      host_u.send(32'h0080_0103, 24, 0);
      rf_run = 1'b1;
      ratio(1, 259);
      end_of_test();
   end
endmodule
`default_nettype wire
